// [rtl/tppwm_params.svh]
// register offsets, field positions and reset values
`ifndef TPPWM_PARAMS_SVH
`define TPPWM_PARAMS_SVH

// register byte offsets on the apb bus
`define TPPWM_OFS_PERIOD   12'h000
`define TPPWM_OFS_DEAD     12'h004
`define TPPWM_OFS_MINPULSE 12'h008
`define TPPWM_OFS_SYNCW    12'h00c
`define TPPWM_OFS_DUTY_A   12'h010
`define TPPWM_OFS_DUTY_B   12'h014
`define TPPWM_OFS_DUTY_C   12'h018
`define TPPWM_OFS_OUTSEL   12'h01c
`define TPPWM_OFS_MODE     12'h020
`define TPPWM_OFS_STATUS   12'h024

// field positions
`define TPPWM_MODE_DOUBLE_BIT 6
`define TPPWM_STAT_HALF_BIT   3
`define TPPWM_STAT_RUN_BIT    0

// reset values
`define TPPWM_SYNCW_RST 8'h27
`define TPPWM_DEAD_RST  10'h000

`endif

// [rtl/tppwm_pkg.sv]
// types shared by the three-phase pwm timing unit
package tppwm_pkg;
   // counter direction / run state of the timing unit
   typedef enum logic [1:0] {
      TPPWM_IDLE,
      TPPWM_UP,
      TPPWM_DOWN
   } tppwm_state_e;
   // count width of the timer
   typedef logic [15:0] tppwm_cnt_t;
endpackage

// [rtl/tppwm_timing_unit.sv]
// three-phase center-based pwm timing unit with apb register slave
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "tppwm_params.svh"

module tppwm_timing_unit
#(
   parameter int CNT_W = 16                // timer width
)
(
   input  wire logic              pclk,    // 200 mhz clock
   input  wire logic              presetn, // async reset, active low
   input  wire logic              psel,    // apb select
   input  wire logic              penable, // apb access phase
   input  wire logic              pwrite,  // apb write
   input  wire logic [11:0]       paddr,   // apb byte address
   input  wire logic [31:0]       pwdata,  // apb write data
   output logic [31:0]            prdata,  // apb read data
   output logic                   pready,  // apb ready
   output logic                   pslverr, // apb error
   output logic                   phase_a_high_out, // phase a high side
   output logic                   phase_a_low_out,  // phase a low side
   output logic                   phase_b_high_out, // phase b high side
   output logic                   phase_b_low_out,  // phase b low side
   output logic                   phase_c_high_out, // phase c high side
   output logic                   phase_c_low_out,  // phase c low side
   output logic                   period_sync_pulse, // sync pulse level
   output logic                   sync_irq,         // sync event pulse
   output logic [8:0]             output_select_act, // latched select
   output logic [15:0]            min_pulse_act     // latched min pulse
);
   import tppwm_pkg::*;

   // software-side registers
   logic [CNT_W-1:0] half_period_count_r; // period in ticks per half
   logic [9:0]       dead_time_count_r;   // dead time count
   logic [15:0]      min_pulse_count_r;   // minimum pulse count
   logic [7:0]       sync_pulse_width_r;  // sync width minus one
   logic [CNT_W-1:0] duty_r [3];          // per-phase duties
   logic [8:0]       output_select_mask_r; // output select
   logic             double_mode_r;       // update mode bit
   logic [4:0]       written_r;           // period, duties, written flags
   // active copies inside the timing unit
   logic [CNT_W-1:0] act_period_r;        // latched period
   logic [9:0]       act_dead_r;          // latched dead time
   logic [CNT_W-1:0] act_duty_r [3];      // latched duties
   logic [8:0]       act_sel_r;           // latched output select
   logic [15:0]      act_minp_r;          // latched min pulse
   // counter and sequencing
   tppwm_state_e     state_r;             // run state
   logic [CNT_W:0]   cnt_r;               // up/down counter
   logic             second_half_r;       // status half flag
   logic [8:0]       sync_cnt_r;          // sync pulse remaining ticks
   logic [CNT_W:0]   start_cnt_r;         // start delay counter
   logic [CNT_W:0]   start_lim_r;         // start delay length
   logic [2:0]       hi_r;                // high-side drives
   logic [2:0]       lo_r;                // low-side drives

   // bus decode
   wire acc      = psel & penable;                   // access phase
   wire wr       = acc & pwrite;                     // write strobe
   wire hit_per  = paddr == `TPPWM_OFS_PERIOD;       // period hit
   wire hit_dt   = paddr == `TPPWM_OFS_DEAD;         // dead time hit
   wire hit_mp   = paddr == `TPPWM_OFS_MINPULSE;     // min pulse hit
   wire hit_sw   = paddr == `TPPWM_OFS_SYNCW;        // sync width hit
   wire hit_da   = paddr == `TPPWM_OFS_DUTY_A;       // duty a hit
   wire hit_db   = paddr == `TPPWM_OFS_DUTY_B;       // duty b hit
   wire hit_dc   = paddr == `TPPWM_OFS_DUTY_C;       // duty c hit
   wire hit_sel  = paddr == `TPPWM_OFS_OUTSEL;       // select hit
   wire hit_mode = paddr == `TPPWM_OFS_MODE;         // mode hit
   wire hit_st   = paddr == `TPPWM_OFS_STATUS;       // status hit
   wire hit_any  = hit_per | hit_dt | hit_mp | hit_sw | hit_da | hit_db
                 | hit_dc | hit_sel | hit_mode | hit_st;
   wire [2:0] hit_duty = {hit_dc, hit_db, hit_da};   // duty hits

   // single-cycle slave, error on unmapped address
   assign pready  = 1'b1;
   assign pslverr = acc & ~hit_any;

   // read mux
   logic [31:0] rd_nxt; // read data source
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      unique case (1'b1)
         hit_per:  rd_nxt = {{(32-CNT_W){1'b0}}, half_period_count_r};
         hit_dt:   rd_nxt = {22'h000000, dead_time_count_r};
         hit_mp:   rd_nxt = {16'h0000, min_pulse_count_r};
         hit_sw:   rd_nxt = {24'h000000, sync_pulse_width_r};
         hit_da:   rd_nxt = {{(32-CNT_W){1'b0}}, duty_r[0]};
         hit_db:   rd_nxt = {{(32-CNT_W){1'b0}}, duty_r[1]};
         hit_dc:   rd_nxt = {{(32-CNT_W){1'b0}}, duty_r[2]};
         hit_sel:  rd_nxt = {23'h000000, output_select_mask_r};
         hit_mode: rd_nxt = 32'(double_mode_r) << `TPPWM_MODE_DOUBLE_BIT;
         hit_st:   rd_nxt = (32'(second_half_r) << `TPPWM_STAT_HALF_BIT)
                          | 32'(state_r != TPPWM_IDLE);
         default:  rd_nxt = 32'h0000_0000;
      endcase
   end

   // registered read data, taken in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel & ~penable & ~pwrite)
         prdata <= rd_nxt;
   end

   // software register writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         half_period_count_r  <= '0;
         dead_time_count_r    <= `TPPWM_DEAD_RST;
         min_pulse_count_r    <= 16'h0000;
         sync_pulse_width_r   <= `TPPWM_SYNCW_RST;
         output_select_mask_r <= 9'h000;
         double_mode_r        <= 1'b0;
      end
      else if (wr)
      begin
         if (hit_per)  half_period_count_r <= pwdata[CNT_W-1:0];
         if (hit_dt)   dead_time_count_r   <= pwdata[9:0];
         if (hit_mp)   min_pulse_count_r   <= pwdata[15:0];
         if (hit_sw)   sync_pulse_width_r  <= pwdata[7:0];
         if (hit_sel)  output_select_mask_r <= pwdata[8:0];
         if (hit_mode) double_mode_r <= pwdata[`TPPWM_MODE_DOUBLE_BIT];
      end
   end

   // duty registers, one per phase
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_duty
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               duty_r[gi] <= '0;
            else if (wr & hit_duty[gi])
               duty_r[gi] <= pwdata[CNT_W-1:0];
         end
      end
   endgenerate

   // start condition
   wire per_wr    = wr & hit_per;                    // period write
   wire all_done  = &written_r[3:0];                 // all written
   wire running   = state_r != TPPWM_IDLE;           // timer runs
   wire start_ev  = ~running & all_done & written_r[4]
                  & (start_cnt_r >= start_lim_r);
   // sync at period start, plus at mid-period in double mode
   wire mid_ev    = running & double_mode_r & (state_r == TPPWM_UP)
                  & (cnt_r + 1'b1 >= {1'b0, act_period_r});
   wire end_ev    = running & (state_r == TPPWM_DOWN) & (cnt_r <= 1);
   wire sync_ev   = start_ev | mid_ev | end_ev;      // load instant

   // written flags and the first-sync delay
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         written_r   <= 5'h00;
         start_cnt_r <= '0;
         start_lim_r <= '0;
      end
      else
      begin
         if (per_wr)
            written_r[0] <= 1'b1;
         if (wr & hit_da)
            written_r[1] <= 1'b1;
         if (wr & hit_db)
            written_r[2] <= 1'b1;
         if (wr & hit_dc)
            written_r[3] <= 1'b1;
         // delay counted from the first period write
         if (per_wr & ~written_r[0])
         begin
            written_r[4] <= 1'b1;
            start_cnt_r  <= '0;
            start_lim_r  <= double_mode_r ?
               {1'b0, pwdata[CNT_W-1:0]} :
               ({1'b0, pwdata[CNT_W-1:0]}
                + {2'b00, pwdata[CNT_W-1:1]});
         end
         // holds at the limit, so late duty writes cannot wrap it
         else if (written_r[4] & ~running & (start_cnt_r < start_lim_r))
            start_cnt_r <= start_cnt_r + 1'b1;
      end
   end

   // up/down counter and latching of active values
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r       <= TPPWM_IDLE;
         cnt_r         <= '0;
         second_half_r <= 1'b0;
         act_period_r  <= '0;
         act_dead_r    <= '0;
         act_sel_r     <= '0;
         act_minp_r    <= '0;
         act_duty_r    <= '{default: '0};
      end
      else
      begin
         if (sync_ev)
         begin
            act_period_r <= half_period_count_r;
            act_dead_r   <= dead_time_count_r;
            act_minp_r   <= min_pulse_count_r;
            act_duty_r   <= duty_r;
            act_sel_r    <= output_select_mask_r;
         end
         unique case (state_r)
            TPPWM_IDLE:
            begin
               if (start_ev)
               begin
                  state_r <= TPPWM_UP;
                  cnt_r   <= '0;
               end
            end
            TPPWM_UP:
            begin
               // turn at the half-period count, once per period
               if (cnt_r + 1'b1 >= {1'b0, act_period_r})
               begin
                  state_r <= TPPWM_DOWN;
                  cnt_r   <= {1'b0, act_period_r};
                  second_half_r <= double_mode_r;
               end
               else
                  cnt_r <= cnt_r + 1'b1;
            end
            TPPWM_DOWN:
            begin
               if (cnt_r <= 1)
               begin
                  state_r       <= TPPWM_UP;
                  cnt_r         <= '0;
                  second_half_r <= 1'b0;
               end
               else
                  cnt_r <= cnt_r - 1'b1;
            end
            default:
               state_r <= TPPWM_IDLE;
         endcase
      end
   end

   // sync pulse width counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sync_cnt_r <= '0;
      // width register is taken at the load edge itself
      // width is register value plus one
      else if (sync_ev)
         sync_cnt_r <= {1'b0, sync_pulse_width_r} + 9'h001;
      else if (sync_cnt_r != '0)
         sync_cnt_r <= sync_cnt_r - 9'h001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sync_irq <= 1'b0;
      else
         sync_irq <= sync_ev;
   end

   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_phase
         // half-duty edges relative to the counter
         wire [CNT_W:0] half_p = {1'b0, act_period_r};     // half period
         wire [CNT_W:0] duty   = {1'b0, act_duty_r[gi]};   // duty count
         // dead time, zero when register is zero
         wire [CNT_W:0] dead   = {{(CNT_W-9){1'b0}}, act_dead_r};
         // high region: counter above period minus duty
         // centered, trimmed by dead time each edge
         wire [CNT_W+1:0] hi_th = {1'b0, half_p} - {1'b0, duty}
                                + {1'b0, dead};
         // low region: counter below period minus duty minus dead
         wire [CNT_W+1:0] lo_th = {1'b0, half_p} - {1'b0, duty}
                                - {1'b0, dead};
         // clamp: below zero is full on, past period off
         // the up half holds 0..P-1 and the down half P..1, so the
         // compares differ by one per half to give even on-times
         wire up_h  = state_r == TPPWM_UP;    // counter rising
         wire hi_up = {1'b0, cnt_r} >= hi_th; // high, rising half
         wire hi_dn = {1'b0, cnt_r} > hi_th;  // high, falling half
         wire lo_up = {1'b0, cnt_r} < lo_th;  // low, rising half
         wire lo_dn = {1'b0, cnt_r} <= lo_th; // low, falling half
         wire hi_on = (duty > dead)
                    & (hi_th[CNT_W+1] | (up_h ? hi_up : hi_dn));
         wire lo_on = ~lo_th[CNT_W+1] & (up_h ? lo_up : lo_dn);
         // in double mode each half uses its own latched values, in single mode both halves use those latched at period start
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               hi_r[gi] <= 1'b0;
               lo_r[gi] <= 1'b0;
            end
            else if (!running)
            begin
               hi_r[gi] <= 1'b0;
               lo_r[gi] <= 1'b0;
            end
            else
            begin
               hi_r[gi] <= hi_on;
               lo_r[gi] <= lo_on;
            end
         end
      end
   endgenerate

   // timing unit outputs
   assign phase_a_high_out  = hi_r[0];
   assign phase_a_low_out   = lo_r[0];
   assign phase_b_high_out  = hi_r[1];
   assign phase_b_low_out   = lo_r[1];
   assign phase_c_high_out  = hi_r[2];
   assign phase_c_low_out   = lo_r[2];
   assign period_sync_pulse = sync_cnt_r != '0;
   assign output_select_act = act_sel_r;
   assign min_pulse_act     = act_minp_r;

endmodule

// [test/tppwm_timing_unit_sva.sv]
// checker for the pwm timing unit ports
`timescale 1ns/1ps
`include "tppwm_params.svh"

module tppwm_timing_unit_sva
(
   input wire logic        pclk,              // clock
   input wire logic        presetn,           // reset, active low
   input wire logic        psel,              // apb select
   input wire logic        penable,           // apb access
   input wire logic        pwrite,            // apb write
   input wire logic [11:0] paddr,             // apb address
   input wire logic [31:0] pwdata,            // apb write data
   input wire logic [31:0] prdata,            // apb read data
   input wire logic        pready,            // apb ready
   input wire logic        pslverr,           // apb error
   input wire logic        phase_a_high_out,  // a high
   input wire logic        phase_a_low_out,   // a low
   input wire logic        phase_b_high_out,  // b high
   input wire logic        phase_b_low_out,   // b low
   input wire logic        phase_c_high_out,  // c high
   input wire logic        phase_c_low_out,   // c low
   input wire logic        period_sync_pulse, // sync level
   input wire logic        sync_irq,          // sync event
   input wire logic [8:0]  output_select_act, // latched select
   input wire logic [15:0] min_pulse_act      // latched min pulse
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire       acc  = psel & penable;               // access phase
   wire       accw = acc & pwrite;                 // write access
   wire [5:0] drv  = {phase_c_low_out, phase_c_high_out, phase_b_low_out,
                      phase_b_high_out, phase_a_low_out, phase_a_high_out};
   logic [3:0] wr_r;                               // period, duties seen
   logic [7:0] sw_r;                               // sync width copy
   logic       mode_r;                             // double mode copy
   logic [8:0] run_r;                              // sync high length
   // shadow the registers that the properties need
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         wr_r   <= 4'h0;
         sw_r   <= `TPPWM_SYNCW_RST;
         mode_r <= 1'b0;
         run_r  <= 9'h000;
      end
      else
      begin
         run_r <= period_sync_pulse ? run_r + 9'h001 : 9'h000;
         if (accw && paddr == `TPPWM_OFS_PERIOD) wr_r[0] <= 1'b1;
         if (accw && paddr == `TPPWM_OFS_DUTY_A) wr_r[1] <= 1'b1;
         if (accw && paddr == `TPPWM_OFS_DUTY_B) wr_r[2] <= 1'b1;
         if (accw && paddr == `TPPWM_OFS_DUTY_C) wr_r[3] <= 1'b1;
         if (accw && paddr == `TPPWM_OFS_SYNCW) sw_r <= pwdata[7:0];
         if (accw && paddr == `TPPWM_OFS_MODE) mode_r <= pwdata[6];
      end
   sequence s_sync_start;
      $rose(period_sync_pulse);
   endsequence
   sequence s_irq_once;
      sync_irq ##1 !sync_irq;
   endsequence
   a_ready_always: assert property (pready)
      else $error("pready low");
   a_unmapped_err: assert property (acc && paddr > 12'h024 |->
      pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_sync_width: assert property ($fell(period_sync_pulse) |->
      run_r == {1'b0, sw_r} + 9'h001)
      else $error("sync width wrong");
   a_irq_on_sync: assert property (s_sync_start |-> ##[0:2] s_irq_once)
      else $error("no irq for sync");
   a_pair_apart: assert property ((drv[0] & drv[1]) == 1'b0 &&
      (drv[2] & drv[3]) == 1'b0 && (drv[4] & drv[5]) == 1'b0)
      else $error("pair both on");
   a_idle_outputs: assert property (wr_r != 4'hf |->
      drv == 6'h00 && !period_sync_pulse)
      else $error("output before start");
   a_single_half: assert property (acc && !pwrite && !mode_r &&
      paddr == `TPPWM_OFS_STATUS |-> !prdata[3])
      else $error("half flag in single mode");
   a_sel_latch: assert property ($changed(output_select_act) ||
      $changed(min_pulse_act) |->
      period_sync_pulse || $past(period_sync_pulse))
      else $error("select changed off sync");
endmodule

bind tppwm_timing_unit tppwm_timing_unit_sva u_sva
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr),
   .phase_a_high_out(phase_a_high_out), .phase_a_low_out(phase_a_low_out),
   .phase_b_high_out(phase_b_high_out), .phase_b_low_out(phase_b_low_out),
   .phase_c_high_out(phase_c_high_out), .phase_c_low_out(phase_c_low_out),
   .period_sync_pulse(period_sync_pulse), .sync_irq(sync_irq),
   .output_select_act(output_select_act), .min_pulse_act(min_pulse_act)
);

// [test/tppwm_gate_model.sv]
// gate driver model: sums on-times between sync rising edges
`timescale 1ns/1ps

module tppwm_gate_model
(
   input  wire logic       pclk,    // clock
   input  wire logic       presetn, // reset, active low
   input  wire logic       sync,    // period sync level
   input  wire logic [5:0] drv,     // six gate drives
   output logic [15:0]     lat [8], // last interval sums
   output logic            fresh    // new sums strobe
);
   logic [15:0] acc_r [8];                  // running sums
   logic        sync_r;                     // delayed sync
   wire         rise = sync & ~sync_r;      // interval boundary
   wire  [7:0]  lvl  = {1'b1, sync, drv};   // slot 7 counts cycles
   // integrate each level, hand the sums over at each boundary
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         sync_r <= 1'b0;
         fresh  <= 1'b0;
         for (int i = 0; i < 8; i++)
         begin
            acc_r[i] <= 16'h0000;
            lat[i]   <= 16'h0000;
         end
      end
      else
      begin
         sync_r <= sync;
         fresh  <= rise;
         for (int i = 0; i < 8; i++)
            if (rise)
            begin
               lat[i]   <= acc_r[i];
               acc_r[i] <= {15'h0000, lvl[i]};
            end
            else
               acc_r[i] <= acc_r[i] + {15'h0000, lvl[i]};
      end
endmodule

// [test/tb_top.sv]
// top testbench for the three-phase pwm timing unit
`timescale 1ns/1ps
`include "tppwm_params.svh"
`define CHK(n,e,s) begin checks_done++; if ((s) !== (e)) begin n_errors++; \
 $display("Error %s exp %0h got %0h", n, e, s); end end

module tb_top;
   import tppwm_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite; // bench drives
   logic [11:0] paddr;                                // apb address
   logic [31:0] pwdata, rd;                           // write, read data
   wire  [31:0] prdata;                               // read data
   wire         pready, pslverr, sync, irq, fresh;    // design answers
   wire  [5:0]  drv;                                  // gate drives
   wire  [8:0]  sel;                                  // latched select
   wire  [15:0] mp;                                   // latched min pulse
   wire  [15:0] lat [8];                              // measured sums
   logic [15:0] sm [8];                               // summed intervals
   logic        er, s1;                               // error, flag copy
   int          n_errors, checks_done, cyc, t0;
   logic [15:0] t_dt [5] = '{16'd3, 16'd0, 16'd3, 16'd3, 16'h3ff};
   logic [15:0] t_du [5] = '{16'd8, 16'd8, 16'd2, 16'd19, 16'd8};
   logic [15:0] t_hi [5] = '{16'd10, 16'd16, 16'd0, 16'd32, 16'd0};
   logic [15:0] t_lo [5] = '{16'd18, 16'd24, 16'd30, 16'd0, 16'd0};

   tppwm_timing_unit u_dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .phase_a_high_out(drv[0]), .phase_a_low_out(drv[1]),
      .phase_b_high_out(drv[2]), .phase_b_low_out(drv[3]),
      .phase_c_high_out(drv[4]), .phase_c_low_out(drv[5]),
      .period_sync_pulse(sync), .sync_irq(irq),
      .output_select_act(sel), .min_pulse_act(mp)
   );
   tppwm_gate_model u_gate
   (
      .pclk(pclk), .presetn(presetn), .sync(sync), .drv(drv),
      .lat(lat), .fresh(fresh)
   );
   // 200 mhz clock and a free cycle count
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;
   task results;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // one apb transfer, waits for pready under a bound
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50)
      begin
         n_errors++;
         results;
      end
   endtask
   // wait for the next sync boundary under a bound
   task wait_new;
      int k;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end while (fresh !== 1'b1 && k < 400);
      if (k >= 400)
      begin
         n_errors++;
         results;
      end
   endtask
   task meas(input int n);
      for (int i = 0; i < 8; i++) sm[i] = 16'h0000;
      repeat (n)
      begin
         wait_new;
         for (int i = 0; i < 8; i++) sm[i] = sm[i] + lat[i];
      end
   endtask
   // reset values, field width, unmapped address
   task t_regs;
      apb(0, `TPPWM_OFS_SYNCW, 0);
      `CHK("sync width", 32'h27, rd)
      apb(0, `TPPWM_OFS_DEAD, 0);
      `CHK("dead", 32'h0, rd)
      apb(0, `TPPWM_OFS_MODE, 0);
      `CHK("mode", 32'h0, rd)
      apb(1, `TPPWM_OFS_DEAD, 32'h7ff);
      apb(0, `TPPWM_OFS_DEAD, 0);
      `CHK("dead max", 32'h3ff, rd)
      apb(0, 12'h030, 0);
      `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped data", 32'h0, rd)
      $display("t_regs done");
   endtask
   // outputs idle until all four written, then first sync
   task t_start;
      apb(1, `TPPWM_OFS_DUTY_A, 8);
      apb(1, `TPPWM_OFS_DUTY_B, 8);
      apb(1, `TPPWM_OFS_DEAD, 3);
      apb(1, `TPPWM_OFS_SYNCW, 4);
      apb(1, `TPPWM_OFS_OUTSEL, 32'h1ff);
      apb(1, `TPPWM_OFS_MINPULSE, 7);
      repeat (60) @(posedge pclk);
      `CHK("idle", 7'h00, {sync, drv})
      apb(1, `TPPWM_OFS_PERIOD, 20);
      t0 = cyc + 2; // model reports a rise two edges late
      apb(1, `TPPWM_OFS_DUTY_C, 8);
      wait_new;
      `CHK("first sync", 1'b1, (cyc - t0 >= 30 && cyc - t0 <= 32))
      `CHK("min pulse", 16'h7, mp)
      `CHK("select", 9'h1ff, sel)
      $display("t_start done");
   endtask
   // single mode on-times, clamping, zero and maximum dead time
   task t_single;
      for (int i = 0; i < 5; i++)
      begin
         apb(1, `TPPWM_OFS_DEAD, {16'h0, t_dt[i]});
         apb(1, `TPPWM_OFS_DUTY_A, {16'h0, t_du[i]});
         apb(1, `TPPWM_OFS_DUTY_B, {16'h0, t_du[i]});
         apb(1, `TPPWM_OFS_DUTY_C, {16'h0, t_du[i]});
         meas(3);
         meas(1);
         for (int p = 0; p < 3; p++)
         begin
            `CHK("high time", t_hi[i], sm[2 * p])
            `CHK("low time", t_lo[i], sm[2 * p + 1])
         end
         `CHK("period", 16'd40, sm[7])
         `CHK("sync len", 16'd5, sm[6])
      end
      $display("t_single done");
   endtask
   // select value takes effect only at the next sync
   task t_select;
      apb(1, `TPPWM_OFS_OUTSEL, 32'h0a5);
      `CHK("select held", 9'h1ff, sel)
      // a load just before the write may report first, so skip it
      wait_new;
      wait_new;
      @(posedge pclk);
      `CHK("select new", 9'h0a5, sel)
      apb(0, `TPPWM_OFS_STATUS, 0);
      `CHK("status single", 32'h1, rd)
      $display("t_select done");
   endtask
   // double mode: mid-period sync, summed halves, half flag
   task t_double;
      apb(1, `TPPWM_OFS_MODE, 32'h40);
      apb(0, `TPPWM_OFS_MODE, 0);
      `CHK("mode", 32'h40, rd)
      apb(1, `TPPWM_OFS_DEAD, 2);
      apb(1, `TPPWM_OFS_DUTY_A, 10);
      apb(1, `TPPWM_OFS_DUTY_B, 10);
      apb(1, `TPPWM_OFS_DUTY_C, 10);
      meas(3);
      meas(1);
      `CHK("half len", 16'd20, sm[7])
      meas(2);
      for (int p = 0; p < 6; p++)
         `CHK("double time", 16'd16, sm[p])
      `CHK("double period", 16'd40, sm[7])
      wait_new;
      apb(0, `TPPWM_OFS_STATUS, 0);
      s1 = rd[3];
      wait_new;
      apb(0, `TPPWM_OFS_STATUS, 0);
      `CHK("half flag", 1'b1, s1 ^ rd[3])
      $display("t_double done");
   endtask
   // main sequence
   initial
   begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; n_errors = 0; checks_done = 0;
      cyc = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_start;
      t_single;
      t_select;
      t_double;
      results;
   end
endmodule
